// ===== include/nvmcfg_pkg.sv
// package for the nvm clock / option configuration block
package nvmcfg_pkg;
  // ****************************************************************
  // register map (byte addresses, own choice)
  // ****************************************************************
  localparam logic [11:0] OFF_CLOCK_DIVIDER = 12'h000;
  localparam logic [11:0] OFF_OPTIONS       = 12'h004;
  localparam logic [11:0] OFF_CONFIG        = 12'h008;
  localparam logic [11:0] OFF_STATUS        = 12'h00c;
  localparam logic [11:0] OFF_KEY_BASE      = 12'h010;
  localparam logic [11:0] OFF_KEY_LAST      = 12'h02c;

  // ****************************************************************
  // field positions and values
  // ****************************************************************
  localparam int BIT_DIV_LOADED   = 7;
  localparam int BIT_PRESCALE     = 6;
  localparam int BIT_UNLOCK_ALLOW = 7;
  localparam int BIT_REDIRECT_OFF = 6;
  localparam int BIT_SPLIT_OPTION = 5;
  localparam int BIT_HALF_CHOICE  = 6;
  localparam int BIT_UNLOCK_SEL   = 5;
  localparam logic [1:0] CODE_UNSECURED = 2'h2;
  localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
  localparam logic [7:0] RST_CONFIG        = 8'h00;
  localparam logic [2:0] PRESCALE_CYCLES   = 3'h7;
  localparam int         KEY_BYTES         = 8;

  // ****************************************************************
  // carried groups
  // ****************************************************************
  typedef struct packed {
    logic       unlock_allow;
    logic       redirect_off;
    logic       split_option;
    logic [1:0] protection_state_code;
  } nvmcfg_opt_t;

  typedef struct packed {
    logic       access_valid;
    logic       access_write;
    logic       access_secure;
    logic       access_debug;
    logic [2:0] sector_byte;
  } nvmcfg_acc_t;

  typedef struct packed {
    logic       eeprom_page;
    logic       erase_page0;
    logic       erase_page1;
    logic       content_allow;
    logic       pe_allow;
  } nvmcfg_map_t;
endpackage : nvmcfg_pkg

// ===== rtl/nvmcfg_top.sv
// nvm clock divider, options register, eeprom mapping and backdoor unlock
// Overview of operation
// - only one eeprom half is visible; half choice picks which
// - split option 0: each sector split in two 4-byte halves at same addresses
// - split mode sector erase clears all eight bytes, both halves
// - split option 1: whole sector in one page; erase only visible sector
// - divider bit 7 read-only flag; bits 6:0 readable, written only once
// - reset clears loaded flag; first divider write sets it, any data
// - program and erase refused until loaded flag is set
// - prescale bit 6 picks bus clock or bus clock divided by eight
// - divider divides selected input by divisor field plus one
// - each timing pulse is one memory clock cycle; sequencer counts pulses
// - options register loaded from the nonvolatile byte in the first enabled cycle after reset
// - unlock allow bit gates backdoor unlock by eight ordered key bytes
// - key writes accepted only from secured firmware, never debug path
// - options bit 6 is vector redirect off, 0 means redirect enabled
// - options bit 5 is the eeprom split option
// - protection code 1:0 is unsecured; every other code is secure
// - secure device denies content access to unsecured sources
// - code becomes 1:0 after key match or successful blank check
// - unlock select 1 makes key writes compares, else command start
// - blocked access ignores writes and reads back zero
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module nvmcfg_top
  import nvmcfg_pkg::*;
#(
  parameter logic [7:0] NV_OPTIONS_DEFAULT = 8'h02
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  input  wire logic                 CLK_EN,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic [7:0]           NV_OPTIONS_BYTE,
  input  wire logic [63:0]          NV_BACKKEY,
  input  wire logic                 BLANK_CHECK_OK,
  input  wire logic                 KEY_WRITE_SECURE,
  input  wire nvmcfg_pkg::nvmcfg_acc_t ACC,
  output nvmcfg_pkg::nvmcfg_map_t   MAP,
  output nvmcfg_pkg::nvmcfg_opt_t   OPT,
  output logic                      NVM_CLK_PULSE,
  output logic                      KEY_CMD_START
);
  import nvmcfg_pkg::*;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire        wr_acc   = PSEL & PENABLE & PWRITE & CLK_EN;
  wire        rd_acc   = PSEL & ~PWRITE;
  wire        hit_div  = (PADDR == OFF_CLOCK_DIVIDER);
  wire        hit_opt  = (PADDR == OFF_OPTIONS);
  wire        hit_cfg  = (PADDR == OFF_CONFIG);
  wire        hit_sts  = (PADDR == OFF_STATUS);
  wire        hit_key  = (PADDR >= OFF_KEY_BASE) && (PADDR <= OFF_KEY_LAST)
                         && (PADDR[1:0] == 2'h0);
  wire        hit_any  = hit_div | hit_opt | hit_cfg | hit_sts | hit_key;
  wire [2:0]  key_idx  = 3'(PADDR[4:2] - 3'h4);

  // zero-wait slave; unmapped addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_any;

  // ****************************************************************
  // state registers
  // ****************************************************************
  logic [7:0]  div_r;        // bit 7 loaded flag, 6 prescale, 5:0 divisor
  logic [7:0]  opt_r;        // working options copy
  logic [7:0]  cfg_r;        // half choice / unlock select
  logic        unsec_r;      // unlocked until next reset
  logic [3:0]  key_cnt_r;    // next expected key byte index
  logic        key_bad_r;    // a key byte mismatched, came out of order, or came from unsecured firmware or the debug path
  logic [2:0]  pre_cnt_r;
  logic [5:0]  div_cnt_r;
  logic        pulse_r;
  logic [31:0] rdata_r;
  logic        opt_loaded_r; // options captured since the last reset

  wire divisor_loaded_flag = div_r[BIT_DIV_LOADED];
  wire prescale_by_eight   = div_r[BIT_PRESCALE];
  wire eeprom_half_choice  = cfg_r[BIT_HALF_CHOICE];
  wire unlock_write_select = cfg_r[BIT_UNLOCK_SEL];
  wire backdoor_unlock_allow = opt_r[BIT_UNLOCK_ALLOW];

  // ****************************************************************
  // clock divider register
  // ****************************************************************
  // only the first write lands; the flag stays read-only for software
  wire       div_we  = wr_acc & hit_div & ~divisor_loaded_flag;
  wire [7:0] div_nxt = {1'b1, PWDATA[6:0]};

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      div_r <= RST_CLOCK_DIVIDER;
    end else if (div_we) begin
      div_r <= div_nxt;
    end
  end

  // ****************************************************************
  // memory clock generation
  // ****************************************************************
  // prescale tick is every cycle or every eighth; divisor counts ticks
  wire pre_tick = ~prescale_by_eight | (pre_cnt_r == PRESCALE_CYCLES);
  wire div_wrap = pre_tick & (div_cnt_r == div_r[5:0]);

  // the divider only runs once loaded, so no pulse reaches the sequencer early
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !divisor_loaded_flag) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      pulse_r   <= 1'b0;
    end else if (CLK_EN) begin
      pre_cnt_r <= prescale_by_eight ? 3'(pre_cnt_r + 3'h1) : 3'h0;
      div_cnt_r <= div_wrap ? 6'h00 : (pre_tick ? 6'(div_cnt_r + 6'h1) : div_cnt_r);
      pulse_r   <= div_wrap;
    end
  end
  assign NVM_CLK_PULSE = pulse_r;

  // ****************************************************************
  // options register and configuration register
  // ****************************************************************
  // options take the default under reset, then capture the nonvolatile byte once after release
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      opt_r <= NV_OPTIONS_DEFAULT;
    end else if (CLK_EN && !opt_loaded_r) begin
      opt_r <= NV_OPTIONS_BYTE;
    end
  end

  // capture flag: one clocked load after release, never a port under reset
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      opt_loaded_r <= 1'b0;
    end else if (CLK_EN) begin
      opt_loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cfg_r <= RST_CONFIG;
    end else if (wr_acc && hit_cfg) begin
      cfg_r <= {1'b0, PWDATA[6:5], 5'h00};
    end
  end

  // ****************************************************************
  // backdoor key comparison
  // ****************************************************************
  // a key write counts only from secured firmware with unlock select set
  wire key_wr   = wr_acc & hit_key & unlock_write_select;
  wire key_ok   = key_wr & KEY_WRITE_SECURE & ~ACC.access_debug;
  wire [7:0] key_ref = NV_BACKKEY[63 - 8*key_idx -: 8];
  wire key_good = key_ok & ({1'b0, key_idx} == key_cnt_r) & (PWDATA[7:0] == key_ref);
  wire sel_fall = wr_acc & hit_cfg & unlock_write_select & ~PWDATA[BIT_UNLOCK_SEL];
  wire key_match = sel_fall & backdoor_unlock_allow & ~key_bad_r
                   & (key_cnt_r == 4'(KEY_BYTES));
  assign KEY_CMD_START = wr_acc & hit_key & ~unlock_write_select
                         & divisor_loaded_flag;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || sel_fall) begin
      key_cnt_r <= 4'h0;
      key_bad_r <= 1'b0;
    end else if (key_wr) begin
      key_cnt_r <= 4'(key_cnt_r + 4'h1);
      key_bad_r <= key_bad_r | ~key_good;
    end
  end

  // unlock holds until reset; reset wins over a set, nothing else clears it
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      unsec_r <= 1'b0;
    end else if (key_match || (CLK_EN && BLANK_CHECK_OK)) begin
      unsec_r <= 1'b1;
    end
  end

  // ****************************************************************
  // derived outputs
  // ****************************************************************
  wire [1:0] code_now = unsec_r ? CODE_UNSECURED : opt_r[1:0];
  wire       secure   = (code_now != CODE_UNSECURED);
  wire       content_allow = ~secure | (ACC.access_secure & ~ACC.access_debug);
  wire       split_mode = ~opt_r[BIT_SPLIT_OPTION];

  // one pattern per struct, so each output variable has exactly one driver
  assign OPT = '{
    unlock_allow:          backdoor_unlock_allow,
    redirect_off:          opt_r[BIT_REDIRECT_OFF],
    split_option:          opt_r[BIT_SPLIT_OPTION],
    protection_state_code: code_now
  };

  // one visible half; split mode erases both halves, whole mode only visible page
  assign MAP = '{
    eeprom_page:   eeprom_half_choice,
    erase_page0:   split_mode | ~eeprom_half_choice,
    erase_page1:   split_mode | eeprom_half_choice,
    content_allow: content_allow,
    pe_allow:      divisor_loaded_flag
  };

  // ****************************************************************
  // read data
  // ****************************************************************
  wire [7:0] sts_byte = {4'h0, secure, split_mode, unsec_r, divisor_loaded_flag};
  wire [7:0] rd_byte  = hit_div ? div_r :
                        hit_opt ? {opt_r[7:5], 3'h0, code_now} :
                        hit_cfg ? cfg_r :
                        hit_sts ? sts_byte : 8'h00;   // key slots read zero

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rdata_r <= 32'h0000_0000;
    end else if (CLK_EN && rd_acc && !PENABLE) begin
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end
  assign PRDATA = rdata_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_once;
    @(posedge CLK_SYS) disable iff (!RST_N)
      $past(divisor_loaded_flag) |-> $stable(div_r[6:0]);
  endproperty
  a_once: assert property (p_once) else $error("divider changed after load");

  property p_first;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (wr_acc && hit_div && !divisor_loaded_flag) |=> divisor_loaded_flag;
  endproperty
  a_first: assert property (p_first) else $error("first write did not load");

  property p_gate;
    @(posedge CLK_SYS) disable iff (!RST_N)
      !divisor_loaded_flag |-> (!MAP.pe_allow && !KEY_CMD_START && !NVM_CLK_PULSE);
  endproperty
  a_gate: assert property (p_gate) else $error("program allowed unloaded");

  property p_code;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (OPT.protection_state_code != 2'h2) |-> !MAP.content_allow || ACC.access_secure;
  endproperty
  a_code: assert property (p_code) else $error("secure content exposed");

  property p_unlock;
    @(posedge CLK_SYS) disable iff (!RST_N)
      key_match |=> (OPT.protection_state_code == 2'h2) [*3];
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock did not stick");

  property p_nokey;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (opt_loaded_r && !OPT.unlock_allow && !BLANK_CHECK_OK
       && OPT.protection_state_code != 2'h2) |=> (OPT.protection_state_code != 2'h2);
  endproperty
  a_nokey: assert property (p_nokey) else $error("unlock without allow");

  property p_erase;
    @(posedge CLK_SYS) disable iff (!RST_N)
      split_mode |-> (MAP.erase_page0 && MAP.erase_page1);
  endproperty
  a_erase: assert property (p_erase) else $error("split erase partial");

  property p_whole;
    @(posedge CLK_SYS) disable iff (!RST_N)
      !split_mode |-> (MAP.erase_page0 != MAP.erase_page1);
  endproperty
  a_whole: assert property (p_whole) else $error("whole erase wrong page");

  property p_pulse;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (NVM_CLK_PULSE && CLK_EN && div_r[6:0] == 7'h01) |=> !NVM_CLK_PULSE ##1 NVM_CLK_PULSE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("divide by two wrong");

  // options load once per reset; software has no write path into them
  property p_opt_hold;
    @(posedge CLK_SYS) disable iff (!RST_N)
      opt_loaded_r |=> $stable(opt_r);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("options changed");

  property p_flag_sticky;
    @(posedge CLK_SYS) disable iff (!RST_N)
      divisor_loaded_flag |=> divisor_loaded_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared");

  property p_unsec_sticky;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (opt_loaded_r && OPT.protection_state_code == 2'h2)
      |=> (OPT.protection_state_code == 2'h2);
  endproperty
  a_unsec_sticky: assert property (p_unsec_sticky) else $error("unlock lost");

  property p_blank;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (CLK_EN && BLANK_CHECK_OK) |=> (OPT.protection_state_code == 2'h2);
  endproperty
  a_blank: assert property (p_blank) else $error("blank check ignored");

  property p_key_zero;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (PSEL && !PENABLE && !PWRITE && CLK_EN && hit_key) |=> (PRDATA == 32'h0000_0000);
  endproperty
  a_key_zero: assert property (p_key_zero) else $error("key slot read nonzero");

  property p_pulse_one;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (NVM_CLK_PULSE && CLK_EN && div_r[6:0] != 7'h00) |=> !NVM_CLK_PULSE;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one");

  property p_dbg_deny;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (OPT.protection_state_code != 2'h2 && ACC.access_debug) |-> !MAP.content_allow;
  endproperty
  a_dbg_deny: assert property (p_dbg_deny) else $error("debug reached content");

  property p_key_cmd;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (wr_acc && hit_key && unlock_write_select) |-> !KEY_CMD_START;
  endproperty
  a_key_cmd: assert property (p_key_cmd) else $error("key write started command");

  c_load:   cover property (@(posedge CLK_SYS) wr_acc && hit_div);
  c_unlock: cover property (@(posedge CLK_SYS) key_match);
  c_blank:  cover property (@(posedge CLK_SYS) BLANK_CHECK_OK && !unsec_r);
  c_split:  cover property (@(posedge CLK_SYS) split_mode && MAP.eeprom_page);
  c_block:  cover property (@(posedge CLK_SYS) ACC.access_valid && ACC.access_write
                            && ACC.sector_byte == 3'h0 && !MAP.content_allow);
endmodule : nvmcfg_top

// ===== dv/nvmcfg_top_tb.sv
// self-checking bench for the nvm clock divider, options and eeprom mapping block
`timescale 1ns/1ps
module nvmcfg_top_tb;
  import nvmcfg_pkg::*;
  // ****************************************************************
  // stimulus signals
  // ****************************************************************
  logic        CLK_SYS, RST_N, CLK_EN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        BLANK_CHECK_OK, KEY_WRITE_SECURE, NVM_CLK_PULSE, KEY_CMD_START;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [7:0]  NV_OPTIONS_BYTE;
  logic [63:0] NV_BACKKEY;
  logic        err;
  nvmcfg_acc_t ACC;
  nvmcfg_map_t MAP;
  nvmcfg_opt_t OPT;
  int          errors, cmp_count, kcmd;
  localparam logic [63:0] KEY = 64'h1122334455667788;

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

  nvmcfg_top nvmcfg_top_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .NV_OPTIONS_BYTE(NV_OPTIONS_BYTE),
    .NV_BACKKEY(NV_BACKKEY), .BLANK_CHECK_OK(BLANK_CHECK_OK),
    .KEY_WRITE_SECURE(KEY_WRITE_SECURE), .ACC(ACC), .MAP(MAP), .OPT(OPT),
    .NVM_CLK_PULSE(NVM_CLK_PULSE), .KEY_CMD_START(KEY_CMD_START));

  // ****************************************************************
  // clock, command-start monitor, watchdog
  // ****************************************************************
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) if (KEY_CMD_START === 1'b1) kcmd++;
  // whole sequence needs well under a thousand cycles; this bound leaves ample margin
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    errors++;
    finish_test();
  end

  // ****************************************************************
  // bus and helper tasks
  // ****************************************************************
  // one apb transfer; returns at the falling edge so checks see settled outputs
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge CLK_SYS);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= wd;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin @(posedge CLK_SYS); end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    @(negedge CLK_SYS);
  endtask : apb

  task do_reset(input logic [7:0] nonvolatile_options_byte);
    @(posedge CLK_SYS);
    RST_N <= 1'b0; NV_OPTIONS_BYTE <= nonvolatile_options_byte;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (2) @(negedge CLK_SYS);
  endtask : do_reset

  task set_acc(input logic sec, input logic dbg);
    @(posedge CLK_SYS);
    ACC <= {1'b1, 1'b1, sec, dbg, 3'h0};
    @(negedge CLK_SYS);
  endtask : set_acc

  // unlock select on, eight ordered key bytes, unlock select off
  task key_seq(input logic [63:0] k);
    apb(OFF_CONFIG, 1'b1, 32'h00000020);
    for (int i = 0; i < KEY_BYTES; i++) apb(OFF_KEY_BASE + 12'(4 * i), 1'b1, {24'h0, k[63 - 8 * i -: 8]});
    apb(OFF_CONFIG, 1'b1, 32'h00000000);
  endtask : key_seq

  // cycles between two memory clock pulses, sampled on the falling edge where the pulse is settled
  task period(input int exp);
    int n;
    int c;
    n = 0;
    c = 0;
    while (NVM_CLK_PULSE !== 1'b1 && n < 300) begin @(negedge CLK_SYS); n++; end
    do begin @(negedge CLK_SYS); c++; end while (NVM_CLK_PULSE !== 1'b1 && c < 300);
    `CHK("pulse_period", exp, c)
  endtask : period

  task finish_test;
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    errors = 0; cmp_count = 0; kcmd = 0;
    RST_N = 1'b0; CLK_EN = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = 12'h000; PWDATA = 32'h0; NV_OPTIONS_BYTE = 8'h00; NV_BACKKEY = KEY;
    BLANK_CHECK_OK = 1'b0; KEY_WRITE_SECURE = 1'b1; ACC = '0;
    // unsecured, whole-sector mode, redirect off
    do_reset(8'h62);
    `CHK("opt", 5'b01110, OPT)
    `CHK("opt_code", 2'h2, OPT.protection_state_code)
    apb(OFF_OPTIONS, 1'b1, 32'h000000ff);
    @(posedge CLK_SYS) NV_OPTIONS_BYTE <= 8'h00;
    apb(OFF_OPTIONS, 1'b0, 32'h0);
    `CHK("options_rd", 32'h00000062, rd)
    `CHK("opt_split", 1'b1, OPT.split_option)
    apb(OFF_CLOCK_DIVIDER, 1'b0, 32'h0);
    `CHK("div_rst", 32'h00000000, rd)
    `CHK("pe_off", 1'b0, MAP.pe_allow)
    apb(OFF_KEY_BASE, 1'b1, 32'h00000011);
    `CHK("cmd_unloaded", 0, kcmd)
    // smallest real divide: bus clock over two, no prescale
    apb(OFF_CLOCK_DIVIDER, 1'b1, 32'h00000001);
    apb(OFF_CLOCK_DIVIDER, 1'b0, 32'h0);
    `CHK("div_rd", 32'h00000081, rd)
    `CHK("pe_on", 1'b1, MAP.pe_allow)
    period(2);
    apb(OFF_CLOCK_DIVIDER, 1'b1, 32'h000000ff);
    apb(OFF_CLOCK_DIVIDER, 1'b0, 32'h0);
    `CHK("div_once", 32'h00000081, rd)
    period(2);
    for (int h = 1; h >= 0; h--) begin
      apb(OFF_CONFIG, 1'b1, 32'(h) << BIT_HALF_CHOICE);
      `CHK("page", 1'(h), MAP.eeprom_page)
      `CHK("erase_whole", {1'(h == 0), 1'(h)}, {MAP.erase_page0, MAP.erase_page1})
    end
    apb(OFF_KEY_BASE, 1'b1, 32'h00000011);
    `CHK("cmd_start", 1, kcmd)
    apb(OFF_KEY_LAST, 1'b0, 32'h0);
    `CHK("key_rd", 32'h00000000, rd)
    apb(12'h100, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err)
    set_acc(1'b0, 1'b1);
    `CHK("allow_unsec", 1'b1, MAP.content_allow)
    // second reset: secure, split mode, backdoor disallowed
    do_reset(8'h03);
    apb(OFF_CLOCK_DIVIDER, 1'b0, 32'h0);
    `CHK("div_rst2", 32'h00000000, rd)
    `CHK("opt_sec", 2'h3, OPT.protection_state_code)
    `CHK("deny_dbg", 1'b0, MAP.content_allow)
    set_acc(1'b1, 1'b0);
    `CHK("allow_sec", 1'b1, MAP.content_allow)
    apb(OFF_CLOCK_DIVIDER, 1'b1, 32'h0000004c);
    period(104);
    apb(OFF_CONFIG, 1'b1, 32'h00000040);
    `CHK("erase_split", 2'b11, {MAP.erase_page0, MAP.erase_page1})
    `CHK("page_split", 1'b1, MAP.eeprom_page)
    key_seq(KEY);
    `CHK("key_disallowed", 2'h3, OPT.protection_state_code)
    @(posedge CLK_SYS) BLANK_CHECK_OK <= 1'b1;
    @(posedge CLK_SYS) BLANK_CHECK_OK <= 1'b0;
    @(negedge CLK_SYS);
    `CHK("blank_unsec", 2'h2, OPT.protection_state_code)
    apb(OFF_STATUS, 1'b0, 32'h0);
    `CHK("status", 32'h00000007, rd)
    // third reset: secure, backdoor allowed
    do_reset(8'h80);
    kcmd = 0;
    // 25 MHz over eight over sixteen puts the memory clock near 195 kHz
    apb(OFF_CLOCK_DIVIDER, 1'b1, 32'h0000004f);
    period(128);
    set_acc(1'b1, 1'b1);
    key_seq(KEY);
    `CHK("key_debug", 2'h0, OPT.protection_state_code)
    set_acc(1'b1, 1'b0);
    key_seq(KEY ^ 64'h1);
    `CHK("key_wrong", 2'h0, OPT.protection_state_code)
    key_seq(KEY);
    `CHK("key_match", 2'h2, OPT.protection_state_code)
    `CHK("no_cmd", 0, kcmd)
    finish_test();
  end
endmodule : nvmcfg_top_tb
